// ===== hw/rpms_pkg.sv
// Shared constants, types and the step delay table of the rail power mode sequencer.
package rpms_pkg;

  localparam int RAIL_COUNT = 6;
  localparam int SLOT_W = 4;
  localparam int VSEL_W = 8;
  localparam int BUCK_COUNT = 3;

  // Rail positions in every per-rail vector.
  localparam int RAIL_BUCK1 = 0;
  localparam int RAIL_BUCK2 = 1;
  localparam int RAIL_BUCK3 = 2;
  localparam int RAIL_LDO1 = 3;
  localparam int RAIL_LDO2 = 4;
  localparam int RAIL_LDO3 = 5;

  // Clock and timing.
  localparam int CLK_MHZ = 250;
  localparam int STEP_UNIT_US = 32;
  localparam int STEP_UNIT_CYCLES = STEP_UNIT_US * CLK_MHZ;
  localparam int STARTUP_WINDOW_MS = 100;
  localparam int STARTUP_WINDOW_CYCLES = STARTUP_WINDOW_MS * 1000 * CLK_MHZ;

  // Reset values.
  localparam logic [3:0] STEP_CODE_RESET = 4'h3;
  localparam logic [5:0] HOST_ENABLE_RESET = 6'h1D;
  localparam logic [7:0] VSEL_RESET = 8'h00;

  // Output voltage resolution of each buck, in units of 0.01 mV per code.
  localparam int BUCK1_LSB_10UV = 625;
  localparam int BUCK2_LSB_10UV = 1250;
  localparam int BUCK3_LSB_10UV = 1250;

  typedef enum logic [2:0] {
    RPMS_RESET = 3'b000,
    RPMS_LOAD = 3'b001,
    RPMS_UP = 3'b010,
    RPMS_NORMAL = 3'b011,
    RPMS_DOWN = 3'b100,
    RPMS_STANDBY = 3'b101
  } rpms_state_t;

  typedef enum logic [1:0] {
    RPMS_PWM = 2'b00,
    RPMS_PFM = 2'b01,
    RPMS_AUTO = 2'b10
  } rpms_buck_mode_t;

  // Step delay in 32 us units per code; code 3 gives 128 us, code 15 about 8 ms.
  function automatic logic [8:0] step_units(input logic [3:0] code);
    logic [8:0] units;
    units = 9'h001;
    case (code)
      4'h0: units = 9'h001;
      4'h1: units = 9'h002;
      4'h2: units = 9'h003;
      4'h3: units = 9'h004;
      4'h4: units = 9'h006;
      4'h5: units = 9'h008;
      4'h6: units = 9'h00C;
      4'h7: units = 9'h010;
      4'h8: units = 9'h018;
      4'h9: units = 9'h020;
      4'hA: units = 9'h030;
      4'hB: units = 9'h040;
      4'hC: units = 9'h060;
      4'hD: units = 9'h080;
      4'hE: units = 9'h0C0;
      default: units = 9'h100;
    endcase
    return units;
  endfunction

endpackage

// ===== hw/rpms_step_timer.sv
// Programmable step timer that pulses once per sequencer step.
`timescale 1ns/1ps
`default_nettype none
module rpms_step_timer #(
  parameter int UNIT_CYCLES = rpms_pkg::STEP_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [3:0] code,
  output logic tick
);
  localparam int CW = $clog2(UNIT_CYCLES + 1);
  localparam logic [CW-1:0] UNIT_LAST = CW'(UNIT_CYCLES - 1);

  logic [CW-1:0] unit_cnt;
  logic [8:0] unit_idx;
  wire logic unit_done = (unit_cnt == UNIT_LAST);
  wire logic [8:0] unit_last = rpms_pkg::step_units(code) - 9'h001;

  // Compare with >= so a code lowered mid-step cannot stretch the step.
  assign tick = run && unit_done && (unit_idx >= unit_last);

  always_ff @(posedge clk)
  begin
    if (rst || !run || tick)
    begin
      unit_cnt <= '0;
      unit_idx <= 9'h000;
    end
    else if (unit_done)
    begin
      unit_cnt <= '0;
      unit_idx <= unit_idx + 9'h001;
    end
    else
    begin
      unit_cnt <= unit_cnt + CW'(1);
    end
  end
endmodule // rpms_step_timer
`default_nettype wire

// ===== hw/rpms_slot_decode.sv
// Per-rail decode of sequencer slot assignments against the current step.
`timescale 1ns/1ps
`default_nettype none
module rpms_slot_decode #(
  parameter int RAILS = rpms_pkg::RAIL_COUNT,
  parameter int SW = rpms_pkg::SLOT_W
) (
  input wire logic [SW-1:0] step,
  input wire logic [RAILS*SW-1:0] slots,
  input wire logic [SW-1:0] limit,
  output logic [RAILS-1:0] hit,
  output logic [RAILS-1:0] valid,
  output logic [RAILS-1:0] below
);
  genvar i;
  generate
    for (i = 0; i < RAILS; i = i + 1)
    begin : g_rail
      wire logic [SW-1:0] slot = slots[i*SW +: SW];
      // Slots outside 1..limit-1 are never sequenced and stay under host control.
      assign valid[i] = (slot != '0) && (slot < limit);
      // Every rail sharing the slot is hit at once.
      assign hit[i] = valid[i] && (slot == step);
      assign below[i] = step < slot;
    end
  endgenerate
endmodule // rpms_slot_decode
`default_nettype wire

// ===== hw/rail_power_mode_sequencer.sv
// Power mode control and slot based rail sequencer for a multi-rail supply device.
`timescale 1ns/1ps
`default_nettype none
module rail_power_mode_sequencer #(
  parameter int RAILS = rpms_pkg::RAIL_COUNT,
  parameter int STEP_UNIT_CYCLES = rpms_pkg::STEP_UNIT_CYCLES,
  parameter int STARTUP_WINDOW_CYCLES = rpms_pkg::STARTUP_WINDOW_CYCLES
) (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic STANDBY_REQUEST,
  input wire logic IO_SUPPLY_RAIL_GOOD,
  input wire logic SHUTDOWN,
  input wire logic CFG_LOAD_DONE,
  input wire logic [3:0] STEP_DELAY_CODE,
  input wire logic [RAILS*rpms_pkg::SLOT_W-1:0] RAIL_STEP_SLOT,
  input wire logic [rpms_pkg::SLOT_W-1:0] DOMAIN1_END,
  input wire logic [rpms_pkg::SLOT_W-1:0] DOMAIN2_END,
  input wire logic [rpms_pkg::SLOT_W-1:0] STEP_LIMIT,
  input wire logic CFG_BUCK1_TWO_PHASE,
  input wire logic [rpms_pkg::BUCK_COUNT*rpms_pkg::VSEL_W-1:0] CFG_BUCK_VSEL,
  input wire logic HOST_ENABLE_WRITE,
  input wire logic [RAILS-1:0] HOST_ENABLE_DATA,
  input wire logic [RAILS-1:0] RAIL_KEEP_IN_STANDBY,
  input wire logic BUCK3_AUTO_SELECT,
  input wire logic [rpms_pkg::BUCK_COUNT-1:0] HOST_VSEL_WRITE,
  input wire logic [rpms_pkg::VSEL_W-1:0] HOST_VSEL_DATA,
  output logic CFG_LOAD_REQ,
  output logic [RAILS-1:0] RAIL_ENABLE,
  output logic [1:0] BUCK1_BANK_ENABLE,
  output logic [1:0] BUCK3_MODE,
  output logic STANDBY_LDO_INPUT_SELECT,
  output logic [rpms_pkg::BUCK_COUNT*rpms_pkg::VSEL_W-1:0] BUCK_VSEL,
  output logic [2:0] SEQ_STATE,
  output logic [rpms_pkg::SLOT_W-1:0] SEQ_STEP,
  output logic [1:0] SEQ_DOMAIN,
  output logic IN_NORMAL,
  output logic IN_STANDBY,
  output logic STARTUP_OVERRUN
);
  localparam int SW = rpms_pkg::SLOT_W;
  localparam int VW = rpms_pkg::VSEL_W;
  localparam int WW = $clog2(STARTUP_WINDOW_CYCLES + 1);
  localparam logic [WW-1:0] WINDOW_LAST = WW'(STARTUP_WINDOW_CYCLES - 1);

  // Pin synchronisers; only the second stage is read.
  logic standby_request_meta;
  logic standby_request_sync;
  logic io_meta;
  logic io_sync;

  rpms_pkg::rpms_state_t state;
  rpms_pkg::rpms_state_t next_state;
  logic [SW-1:0] step;
  logic [SW-1:0] next_step;
  logic [RAILS-1:0] seq_on;
  logic [RAILS-1:0] next_seq_on;
  logic [RAILS-1:0] host_en;
  logic to_reset;
  logic next_to_reset;
  logic [3:0] step_code;
  logic two_phase;
  logic [VW-1:0] vsel [rpms_pkg::BUCK_COUNT];
  logic [WW-1:0] window_cnt;
  logic window_run;
  logic overrun;
  logic [RAILS-1:0] rail_enable;
  logic [1:0] bank_enable;
  logic [1:0] buck3_mode;
  logic ldo1_standby_src;

  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      standby_request_meta <= 1'b0;
      standby_request_sync <= 1'b0;
      io_meta <= 1'b0;
      io_sync <= 1'b0;
    end
    else
    begin
      standby_request_meta <= STANDBY_REQUEST;
      standby_request_sync <= standby_request_meta;
      io_meta <= IO_SUPPLY_RAIL_GOOD;
      io_sync <= io_meta;
    end
  end

  // Step decode: on the way up the decoder looks at the step about to be entered,
  // on the way down at the step about to be left.
  wire logic in_up = (state == rpms_pkg::RPMS_UP);
  wire logic in_down = (state == rpms_pkg::RPMS_DOWN);
  wire logic [SW-1:0] step_inc = step + SW'(1);
  wire logic [SW-1:0] dec_step = in_down ? step : step_inc;
  wire logic [RAILS-1:0] slot_hit;
  wire logic [RAILS-1:0] slot_valid;
  wire logic [RAILS-1:0] slot_below;
  wire logic [RAILS-1:0] cur_below;

  rpms_slot_decode #(
    .RAILS(RAILS),
    .SW(SW)
  ) u_next_decode (
    .step(dec_step),
    .slots(RAIL_STEP_SLOT),
    .limit(STEP_LIMIT),
    .hit(slot_hit),
    .valid(slot_valid),
    .below(slot_below)
  );

  rpms_slot_decode #(
    .RAILS(RAILS),
    .SW(SW)
  ) u_cur_decode (
    .step(step),
    .slots(RAIL_STEP_SLOT),
    .limit(STEP_LIMIT),
    .hit(),
    .valid(),
    .below(cur_below)
  );

  wire logic tick;

  rpms_step_timer #(
    .UNIT_CYCLES(STEP_UNIT_CYCLES)
  ) u_timer (
    .clk(MCLK),
    .rst(SRST),
    .run(in_up || in_down),
    .code(step_code),
    .tick(tick)
  );

  // Keep bits only apply when the descent ends in standby, not in a shutdown.
  wire logic [RAILS-1:0] keep_mask = RAIL_KEEP_IN_STANDBY & {RAILS{~to_reset}};
  wire logic up_last = (step_inc >= STEP_LIMIT) || (step_inc == '0);
  wire logic down_last = (step == '0);
  wire logic start_ok = !standby_request_sync && io_sync && !SHUTDOWN;
  // Rails outside the sequence drop at the start of a descent, unless kept on the way to standby.
  wire logic [RAILS-1:0] down_entry_on = seq_on & ~(~slot_valid & ~RAIL_KEEP_IN_STANDBY);
  wire logic [RAILS-1:0] shut_entry_on = seq_on & slot_valid;

  always_comb
  begin
    next_state = state;
    next_step = step;
    next_seq_on = seq_on;
    next_to_reset = to_reset;
    unique case (state)
      rpms_pkg::RPMS_RESET:
      begin
        next_step = '0;
        next_seq_on = '0;
        next_to_reset = 1'b0;
        if (start_ok)
        begin
          next_state = rpms_pkg::RPMS_LOAD;
        end
      end
      rpms_pkg::RPMS_LOAD:
      begin
        if (CFG_LOAD_DONE)
        begin
          next_state = rpms_pkg::RPMS_UP;
        end
      end
      rpms_pkg::RPMS_UP:
      begin
        if (SHUTDOWN)
        begin
          next_state = rpms_pkg::RPMS_DOWN;
          next_to_reset = 1'b1;
          next_seq_on = shut_entry_on;
        end
        else if (standby_request_sync)
        begin
          next_state = rpms_pkg::RPMS_DOWN;
          next_seq_on = down_entry_on;
        end
        else if (tick && up_last)
        begin
          // Host controlled rails join once the sequence is complete.
          next_state = rpms_pkg::RPMS_NORMAL;
          next_seq_on = seq_on | ~slot_valid;
        end
        else if (tick)
        begin
          // A slot with no rail only spends one step delay.
          next_step = step_inc;
          next_seq_on = seq_on | slot_hit;
        end
      end
      rpms_pkg::RPMS_NORMAL:
      begin
        if (SHUTDOWN)
        begin
          next_state = rpms_pkg::RPMS_DOWN;
          next_to_reset = 1'b1;
          next_seq_on = shut_entry_on;
        end
        else if (standby_request_sync)
        begin
          next_state = rpms_pkg::RPMS_DOWN;
          next_seq_on = down_entry_on;
        end
      end
      rpms_pkg::RPMS_DOWN:
      begin
        if (!to_reset && !standby_request_sync)
        begin
          next_state = rpms_pkg::RPMS_UP;
        end
        else if (tick)
        begin
          next_seq_on = seq_on & ~(slot_hit & ~keep_mask);
          if (down_last)
          begin
            // A shutdown from standby starts at step zero, so kept rails drop here.
            if (to_reset)
            begin
              next_seq_on = '0;
            end
            next_state = to_reset ? rpms_pkg::RPMS_RESET : rpms_pkg::RPMS_STANDBY;
          end
          else
          begin
            next_step = step - SW'(1);
          end
        end
      end
      rpms_pkg::RPMS_STANDBY:
      begin
        if (SHUTDOWN)
        begin
          next_state = rpms_pkg::RPMS_DOWN;
          next_to_reset = 1'b1;
        end
        else if (!standby_request_sync)
        begin
          next_state = rpms_pkg::RPMS_UP;
        end
      end
      default:
      begin
        next_state = rpms_pkg::RPMS_RESET;
      end
    endcase
  end

  // Reset state clears the host settings too, as a full restart would.
  wire logic host_reset = SRST || (state == rpms_pkg::RPMS_RESET);
  wire logic cfg_take = (state == rpms_pkg::RPMS_LOAD) && CFG_LOAD_DONE;

  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      state <= rpms_pkg::RPMS_RESET;
      step <= '0;
      seq_on <= '0;
      to_reset <= 1'b0;
    end
    else
    begin
      state <= next_state;
      step <= next_step;
      seq_on <= next_seq_on;
      to_reset <= next_to_reset;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (host_reset)
    begin
      host_en <= rpms_pkg::HOST_ENABLE_RESET;
    end
    else if (HOST_ENABLE_WRITE)
    begin
      host_en <= HOST_ENABLE_DATA;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (host_reset)
    begin
      step_code <= rpms_pkg::STEP_CODE_RESET;
      two_phase <= 1'b0;
    end
    else if (cfg_take)
    begin
      step_code <= STEP_DELAY_CODE;
      two_phase <= CFG_BUCK1_TWO_PHASE;
    end
  end

  // Host writes in the same cycle as the settings load lose to the load.
  genvar b;
  generate
    for (b = 0; b < rpms_pkg::BUCK_COUNT; b = b + 1)
    begin : g_vsel
      always_ff @(posedge MCLK)
      begin
        if (host_reset)
        begin
          vsel[b] <= rpms_pkg::VSEL_RESET;
        end
        else if (cfg_take)
        begin
          vsel[b] <= CFG_BUCK_VSEL[b*VW +: VW];
        end
        else if (HOST_VSEL_WRITE[b])
        begin
          vsel[b] <= HOST_VSEL_DATA;
        end
      end
      assign BUCK_VSEL[b*VW +: VW] = vsel[b];
    end
  endgenerate

  // Kept buck3 and LDO1 sit in their low power form while the sequence is below their slot.
  wire logic in_standby_st = (state == rpms_pkg::RPMS_STANDBY);
  wire logic parked_zone = in_standby_st || in_up || in_down;
  wire logic [RAILS-1:0] parked = keep_mask & {RAILS{parked_zone}}
                                  & (cur_below | {RAILS{in_standby_st}});
  wire logic [RAILS-1:0] next_rail_enable = next_seq_on & host_en;
  wire logic b1_on = next_rail_enable[rpms_pkg::RAIL_BUCK1];
  wire logic [1:0] next_bank = b1_on ? {two_phase, 1'b1} : 2'b00;
  wire logic [1:0] next_b3_mode = parked[rpms_pkg::RAIL_BUCK3] ? rpms_pkg::RPMS_PFM
                                  : (BUCK3_AUTO_SELECT ? rpms_pkg::RPMS_AUTO
                                  : rpms_pkg::RPMS_PWM);
  wire logic next_ldo1_src = parked[rpms_pkg::RAIL_LDO1];

  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      rail_enable <= '0;
      bank_enable <= 2'b00;
      buck3_mode <= rpms_pkg::RPMS_PWM;
      ldo1_standby_src <= 1'b0;
    end
    else
    begin
      rail_enable <= next_rail_enable;
      bank_enable <= next_bank;
      buck3_mode <= next_b3_mode;
      ldo1_standby_src <= next_ldo1_src;
    end
  end

  // Start-up window is measured from the end of the settings load or from leaving standby until normal mode.
  wire logic up_start = (cfg_take || (in_standby_st && next_state == rpms_pkg::RPMS_UP));

  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      window_cnt <= '0;
      window_run <= 1'b0;
      overrun <= 1'b0;
    end
    else if (up_start)
    begin
      window_cnt <= '0;
      window_run <= 1'b1;
      overrun <= 1'b0;
    end
    else if (state == rpms_pkg::RPMS_NORMAL || state == rpms_pkg::RPMS_RESET)
    begin
      window_run <= 1'b0;
    end
    else if (window_run && window_cnt == WINDOW_LAST)
    begin
      overrun <= 1'b1;
      window_run <= 1'b0;
    end
    else if (window_run)
    begin
      window_cnt <= window_cnt + WW'(1);
    end
  end

  // Domain of the current step; a misordered pointer set makes this meaningless.
  wire logic [1:0] domain = (step == '0) ? 2'h0
                            : (step <= DOMAIN1_END) ? 2'h1
                            : (step <= DOMAIN2_END) ? 2'h2 : 2'h3;

  assign CFG_LOAD_REQ = (state == rpms_pkg::RPMS_LOAD);
  assign RAIL_ENABLE = rail_enable;
  assign BUCK1_BANK_ENABLE = bank_enable;
  assign BUCK3_MODE = buck3_mode;
  assign STANDBY_LDO_INPUT_SELECT = ldo1_standby_src;
  assign SEQ_STATE = state;
  assign SEQ_STEP = step;
  assign SEQ_DOMAIN = domain;
  assign IN_NORMAL = (state == rpms_pkg::RPMS_NORMAL);
  assign IN_STANDBY = in_standby_st;
  assign STARTUP_OVERRUN = overrun;
endmodule // rail_power_mode_sequencer
`default_nettype wire

// ===== verification/rpms_host_model.sv
// Host side model: supply good, settings memory answer and domain pointers.
`timescale 1ns/1ps
`default_nettype none
module rpms_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic load_req,
  input wire logic [3:0] lag,
  input wire logic [3:0] limit,
  output logic load_done,
  output logic io_good,
  output logic [3:0] d1_end,
  output logic [3:0] d2_end,
  output logic [3:0] step_limit
);
  logic [3:0] wait_cnt;
  // Pointers stay strictly increasing; the bench never sets a limit below four.
  assign d1_end = 4'h1;
  assign d2_end = 4'h2;
  assign step_limit = limit;
  // A slow settings memory holds the load state open for lag + 2 cycles.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wait_cnt <= 4'h0;
      io_good <= 1'b0;
      load_done <= 1'b0;
    end
    else
    begin
      io_good <= 1'b1;
      wait_cnt <= load_req ? wait_cnt + 4'h1 : 4'h0;
      load_done <= load_req && wait_cnt == lag;
    end
  end
endmodule // rpms_host_model
`default_nettype wire

// ===== verification/rpms_properties.sv
// Concurrent checks on the rail power mode sequencer ports.
`timescale 1ns/1ps
`default_nettype none
module rpms_properties #(
  parameter int RAILS = 6
) (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic HOST_ENABLE_WRITE,
  input wire logic [RAILS-1:0] HOST_ENABLE_DATA,
  input wire logic [RAILS-1:0] RAIL_KEEP_IN_STANDBY,
  input wire logic [2:0] HOST_VSEL_WRITE,
  input wire logic [7:0] HOST_VSEL_DATA,
  input wire logic [3:0] STEP_LIMIT,
  input wire logic CFG_LOAD_REQ,
  input wire logic [RAILS-1:0] RAIL_ENABLE,
  input wire logic [1:0] BUCK3_MODE,
  input wire logic [23:0] BUCK_VSEL,
  input wire logic [2:0] SEQ_STATE,
  input wire logic [3:0] SEQ_STEP,
  input wire logic IN_NORMAL,
  input wire logic IN_STANDBY
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SRST);
  a_reset_clears_rails: assert property ($fell(SRST) |-> SEQ_STATE == 3'h0 && RAIL_ENABLE == '0)
    else $error("reset left state or rails set");
  a_load_req_state: assert property (CFG_LOAD_REQ == (SEQ_STATE == 3'h1))
    else $error("load request does not match load state");
  a_mode_flags: assert property (IN_NORMAL == (SEQ_STATE == 3'h3) && IN_STANDBY == (SEQ_STATE == 3'h5))
    else $error("mode flags do not match state");
  a_up_step_inc: assert property (SEQ_STATE == 3'h2 && $past(SEQ_STATE) == 3'h2 && $changed(SEQ_STEP)
    |-> SEQ_STEP == $past(SEQ_STEP) + 4'h1)
    else $error("power-up step did not advance by one");
  a_down_step_dec: assert property (SEQ_STATE == 3'h4 && $past(SEQ_STATE) == 3'h4 && $changed(SEQ_STEP)
    |-> SEQ_STEP == $past(SEQ_STEP) - 4'h1)
    else $error("power-down step did not fall by one");
  a_up_below_limit: assert property (SEQ_STATE == 3'h2 |-> SEQ_STEP < STEP_LIMIT)
    else $error("power-up step reached the limit");
  a_reset_rails_off: assert property (SEQ_STATE == 3'h0 && $past(SEQ_STATE) == 3'h0 |-> RAIL_ENABLE == '0)
    else $error("rail enabled in reset state");
  a_host_mask_apply: assert property (IN_NORMAL [*3] ##0 HOST_ENABLE_WRITE ##1 IN_NORMAL [*2]
    |-> RAIL_ENABLE == $past(HOST_ENABLE_DATA, 2))
    else $error("host enable mask not applied");
  a_buck3_standby_pfm: assert property (IN_STANDBY && $past(IN_STANDBY)
    && $past(RAIL_KEEP_IN_STANDBY[rpms_pkg::RAIL_BUCK3]) |-> BUCK3_MODE == rpms_pkg::RPMS_PFM)
    else $error("kept buck3 not in low power mode");
  a_vsel_write_b0: assert property (HOST_VSEL_WRITE == 3'h1 && SEQ_STATE != 3'h0 && !CFG_LOAD_REQ
    |=> BUCK_VSEL[7:0] == $past(HOST_VSEL_DATA))
    else $error("voltage write not taken");
  c_normal: cover property (IN_NORMAL && !$past(IN_NORMAL));
  c_standby: cover property (IN_STANDBY && !$past(IN_STANDBY));
  c_reverse: cover property (SEQ_STATE == 3'h4 ##1 SEQ_STATE == 3'h2);
  c_shutdown: cover property (SEQ_STATE == 3'h4 ##1 SEQ_STATE == 3'h0);
endmodule // rpms_properties
bind rail_power_mode_sequencer rpms_properties #(.RAILS(RAILS)) u_props (.MCLK, .SRST,
  .HOST_ENABLE_WRITE, .HOST_ENABLE_DATA, .RAIL_KEEP_IN_STANDBY, .HOST_VSEL_WRITE,
  .HOST_VSEL_DATA, .STEP_LIMIT, .CFG_LOAD_REQ, .RAIL_ENABLE, .BUCK3_MODE, .BUCK_VSEL,
  .SEQ_STATE, .SEQ_STEP, .IN_NORMAL, .IN_STANDBY);
`default_nettype wire

// ===== verification/rail_power_mode_sequencer_test.sv
// Self-checking bench for the rail power mode sequencer.
`timescale 1ns/1ps
`default_nettype none
module rail_power_mode_sequencer_test;
  localparam int U = 4;
  int seed = 29;
  int error_cnt = 0;
  int n_checks = 0;
  int code, lim;
  int slot[6];
  logic [5:0] mask, keep;
  logic mclk = 1'b0, srst = 1'b1, standby_request = 1'b0, shut = 1'b0, tp = 1'b0, hwr = 1'b0, auto = 1'b0;
  logic [3:0] code_in = 4'h3, lim_in = 4'h5, lag = 4'h0;
  logic [23:0] slot_in = 24'h0, vsel_in = 24'h0;
  logic [5:0] hdat = 6'h0, keep_in = 6'h0;
  logic [2:0] vwr = 3'h0;
  logic [7:0] vdat = 8'h0;
  logic load_req, load_done, io_good, ldo_sel, in_norm, in_standby_request, overrun;
  logic [3:0] d1, d2, lmt, step;
  logic [5:0] rail_en;
  logic [1:0] bank, b3m, dom;
  logic [23:0] vsel;
  logic [2:0] state;

  rail_power_mode_sequencer #(.STEP_UNIT_CYCLES(U), .STARTUP_WINDOW_CYCLES(200)) dut (
    .MCLK(mclk), .SRST(srst), .STANDBY_REQUEST(standby_request), .IO_SUPPLY_RAIL_GOOD(io_good),
    .SHUTDOWN(shut), .CFG_LOAD_DONE(load_done), .STEP_DELAY_CODE(code_in),
    .RAIL_STEP_SLOT(slot_in), .DOMAIN1_END(d1), .DOMAIN2_END(d2), .STEP_LIMIT(lmt),
    .CFG_BUCK1_TWO_PHASE(tp), .CFG_BUCK_VSEL(vsel_in), .HOST_ENABLE_WRITE(hwr),
    .HOST_ENABLE_DATA(hdat), .RAIL_KEEP_IN_STANDBY(keep_in), .BUCK3_AUTO_SELECT(auto),
    .HOST_VSEL_WRITE(vwr), .HOST_VSEL_DATA(vdat), .CFG_LOAD_REQ(load_req),
    .RAIL_ENABLE(rail_en), .BUCK1_BANK_ENABLE(bank), .BUCK3_MODE(b3m),
    .STANDBY_LDO_INPUT_SELECT(ldo_sel), .BUCK_VSEL(vsel), .SEQ_STATE(state), .SEQ_STEP(step),
    .SEQ_DOMAIN(dom), .IN_NORMAL(in_norm), .IN_STANDBY(in_standby_request), .STARTUP_OVERRUN(overrun));
  rpms_host_model host (.clk(mclk), .rst(srst), .load_req(load_req), .lag(lag), .limit(lim_in),
    .load_done(load_done), .io_good(io_good), .d1_end(d1), .d2_end(d2), .step_limit(lmt));

  always #2 mclk = ~mclk;

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // Rails expected on at step t: sequenced up to t, or kept, always under the host mask.
  function automatic logic [5:0] want(input int t, input logic [5:0] k);
    logic [5:0] r;
    for (int i = 0; i < 6; i++)
      r[i] = mask[i] && (k[i] || (slot[i] >= 1 && slot[i] <= t && slot[i] < lim));
    return r;
  endfunction

  task automatic follow(input logic [2:0] goal, input logic [5:0] k, input bit rev);
    int cnt, n;
    logic [3:0] last;
    logic [2:0] lst;
    cnt = 0;
    n = 0;
    last = step;
    lst = state;
    for (int w = 0; w < 4000 && state !== goal; w++)
    begin
      @(negedge mclk);
      cnt++;
      if (step !== last)
      begin
        if (n > 0 && state === lst)
          chk(cnt, (code + 1) * U, "step period");
        chk(dom, step == 0 ? 0 : step <= 1 ? 1 : step <= 2 ? 2 : 3, "domain");
        last = step;
        lst = state;
        n++;
        @(negedge mclk);
        chk(rail_en, want(last, k), "rails");
        cnt = 1;
        if (rev && n == 2)
        begin
          @(posedge mclk);
          standby_request <= 1'b0;
        end
      end
    end
    if (state !== goal)
    begin
      chk(state, goal, "timeout");
      end_of_test();
    end
    @(negedge mclk);
  endtask

  task automatic setup();
    @(posedge mclk);
    code = 2 + ($random(seed) & 1);
    lim = 4 + ($random(seed) & 3);
    for (int i = 0; i < 6; i++)
    begin
      slot[i] = $random(seed) & 7;
      slot_in[4*i +: 4] <= slot[i][3:0];
    end
    code_in <= code[3:0];
    lim_in <= lim[3:0];
    lag <= 4'($random(seed) & 7);
    vsel_in <= 24'($random(seed));
    tp <= 1'($random(seed));
    auto <= 1'($random(seed));
  endtask

  task automatic at_normal();
    chk(rail_en, mask, "normal rails");
    chk(b3m, auto ? 2 : 0, "buck3 mode");
    chk(ldo_sel, 0, "ldo source");
    chk(overrun, 0, "overrun");
  endtask

  initial
  begin
    setup();
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    for (int r = 0; r < 3; r++)
    begin
      mask = 6'h1D;
      follow(3'h3, 6'h00, 1'b0);
      at_normal();
      chk(vsel, vsel_in, "vsel default");
      chk(bank, {tp, 1'b1}, "buck1 banks");
      @(posedge mclk);
      hwr <= 1'b1;
      hdat <= 6'($random(seed)) | 6'h02;
      vwr <= 3'h1 << r;
      vdat <= 8'($random(seed));
      @(posedge mclk);
      hwr <= 1'b0;
      vwr <= 3'h0;
      mask = hdat;
      @(negedge mclk);
      chk(vsel[8*r +: 8], vdat, "vsel write");
      @(negedge mclk);
      chk(rail_en, mask, "host enable");
      keep = (6'($random(seed)) & 6'h33) | (r == 2 ? 6'h0C : 6'h00);
      @(posedge mclk);
      keep_in <= keep;
      standby_request <= 1'b1;
      follow(3'h4, keep, 1'b0);
      if (r == 1)
        follow(3'h3, keep, 1'b1);
      else
      begin
        follow(3'h5, keep, 1'b0);
        chk(rail_en, mask & keep, "standby rails");
        chk(b3m, keep[2] ? 1 : auto ? 2 : 0, "standby buck3");
        chk(ldo_sel, keep[3], "standby ldo source");
        @(posedge mclk);
        standby_request <= 1'b0;
        follow(3'h3, keep, 1'b0);
      end
      at_normal();
      @(posedge mclk);
      shut <= 1'b1;
      follow(3'h4, 6'h00, 1'b0);
      follow(3'h0, 6'h00, 1'b0);
      chk(rail_en, 0, "reset rails");
      setup();
      shut <= 1'b0;
    end
    end_of_test();
  end
endmodule // rail_power_mode_sequencer_test
`default_nettype wire
